// *** pkg/ccc_pkg.sv ***
/*
  Shared constants and carriers for the core configuration and capability
  register block. Assumes a system-control coprocessor port that selects one
  of the configuration registers by a select number.
*/
// What this block does
// - Core configuration and three capability registers are 32 bits in coprocessor space
// - Cache and L2/L3 capability registers are read-only apart from sets-per-way, architecture layout
// - Continuation field of core configuration always reads 1
// - High-kernel, user and boot segment attributes are writable 3-bit fields
// - Boot segment attribute resets to 2 (uncached); 3 means cached
// - Fixed mapping: high-kernel attribute covers 0xC000.0000 to 0xFFFF.FFFF
// - Fixed mapping: user attribute covers 0x0000.0000 to 0x7FFF.FFFF
// - With translation buffer, high-kernel and user attributes are ignored
// - Scratchpad present flags read 1 when that scratchpad is fitted
// - Custom instruction flag reads 1 when extensions are implemented
// - Simple byte enable set: only byte, aligned halfword or word
// - Simple byte enable clear: any nonzero byte enable combination allowed
// - Unlock at 1 makes instruction and data sets-per-way writable
// - With second-level cache, unlock also makes its sets-per-way writable
// - Merge at 1 combines separate write-through stores into one transaction
// - Merge never affects writebacks or uncached writes
// - Implementation register writable fields reset to default behaviour
package ccc_pkg;

  // ---------------------------------------------------------------
  // Register selects within the coprocessor register
  // ---------------------------------------------------------------
  localparam logic [2:0] SEL_CORE_CFG = 3'h0;
  localparam logic [2:0] SEL_CACHE    = 3'h1;
  localparam logic [2:0] SEL_L2L3     = 3'h2;
  localparam logic [2:0] SEL_EXT      = 3'h3;
  localparam logic [2:0] SEL_IMPL     = 3'h7;

  // ---------------------------------------------------------------
  // Core configuration field positions
  // ---------------------------------------------------------------
  localparam int CFG_M_BIT    = 31;
  localparam int CFG_K23_LSB  = 28;
  localparam int CFG_KU_LSB   = 25;
  localparam int CFG_ISP_BIT  = 24;
  localparam int CFG_DSP_BIT  = 23;
  localparam int CFG_UDI_BIT  = 22;
  localparam int CFG_SB_BIT   = 21;
  localparam int CFG_WC_BIT   = 19;
  localparam int CFG_MM_BIT   = 18;
  localparam int CFG_BM_BIT   = 16;
  localparam int CFG_BE_BIT   = 15;
  localparam int CFG_AT_LSB   = 13;
  localparam int CFG_AR_LSB   = 10;
  localparam int CFG_MT_LSB   = 7;
  localparam int CFG_VI_BIT   = 3;
  localparam int CFG_K0_LSB   = 0;

  // Cache capability and L2/L3 sets fields
  localparam int C1_IS_LSB    = 22;
  localparam int C1_DS_LSB    = 13;
  localparam int C2_SS_LSB    = 8;

  // ---------------------------------------------------------------
  // Reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [2:0]  ATTR_UNCACHED  = 3'h2;
  localparam logic [2:0]  ATTR_CACHED    = 3'h3;
  localparam logic [2:0]  RST_BOOT_ATTR  = 3'h2;
  localparam logic [2:0]  RST_SEG_ATTR   = 3'h0;
  localparam logic        RST_WC         = 1'b0;
  localparam logic        RST_MM         = 1'b0;
  localparam logic [31:0] RST_IMPL       = 32'h0000_0000;
  localparam logic [2:0]  MT_TLB         = 3'h1;
  localparam logic [2:0]  MT_FIXED       = 3'h3;

  typedef enum logic [1:0] {
    ccc_wr_wthru,
    ccc_wr_uncached,
    ccc_wr_writeback,
    ccc_wr_wback_cached
  } ccc_wr_kind_e;

  // Coprocessor access carrier
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [2:0]  sel;
    logic [31:0] wdata;
  } ccc_req_s;

endpackage

// *** src/ccc_regs.sv ***
/*
  Core configuration and capability register block with the segment
  cacheability lookup, byte enable legality and store merge decisions
  that those registers steer. Assumes the pipeline presents coprocessor
  reads and writes on the core clock, one per cycle at most.
*/
`timescale 1ns/1ps
module ccc_regs
  import ccc_pkg::*;
#(
  parameter bit       HAS_TLB      = 1'b0,
  parameter bit       HAS_ISPRAM   = 1'b0,
  parameter bit       HAS_DSPRAM   = 1'b0,
  parameter bit       HAS_UDI      = 1'b0,
  parameter bit       SIMPLE_BE    = 1'b1,
  parameter bit       HAS_L2       = 1'b0,
  parameter bit       BIG_ENDIAN   = 1'b0,
  parameter bit       BURST_SUBBLK = 1'b0,
  parameter int       ICACHE_SETS  = 2,
  parameter int       DCACHE_SETS  = 2,
  parameter int       L2_SETS      = 0,
  parameter bit [31:0] CACHE_FIXED = 32'h8000_0000,
  parameter bit [31:0] L2L3_FIXED  = 32'h8000_0000,
  parameter bit [31:0] EXT_FIXED   = 32'h0000_0000,
  parameter bit [31:0] IMPL_WMASK  = 32'h0000_00ff,
  parameter bit [31:0] IMPL_RO     = 32'h0000_0000
)(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Coprocessor register access
  input  wire ccc_req_s     req,
  output logic [31:0]       rdata,
  output logic              rvalid,
  // Segment attribute lookup
  input  wire logic [31:0]  fetch_addr,
  input  wire logic [2:0]   tlb_attr,
  output logic [2:0]        seg_attr,
  // Bus byte enables
  input  wire logic [1:0]   be_addr,
  input  wire logic [3:0]   be_req,
  output logic              be_legal,
  output logic              simple_byte_enable_mode,
  // Store merge decision
  input  wire ccc_wr_kind_e wr_kind,
  output logic              merge_ok,
  // Settings seen by the caches
  output logic [2:0]        icache_sets_per_way,
  output logic [2:0]        dcache_sets_per_way,
  output logic [3:0]        l2_sets_per_way,
  output logic [31:0]       impl_specific_config_reg
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (ICACHE_SETS < 0 || ICACHE_SETS > 7 || DCACHE_SETS < 0 ||
      DCACHE_SETS > 7 || L2_SETS < 0 || L2_SETS > 15) begin : g_bad
    $error("ccc_regs: sets-per-way parameter out of field range");
  end

  localparam logic [2:0] IS_MAX = 3'(ICACHE_SETS);
  localparam logic [2:0] DS_MAX = 3'(DCACHE_SETS);
  localparam logic [3:0] SS_MAX = 4'(L2_SETS);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  high_kernel_seg_cache_attr;
    logic [2:0]  user_seg_cache_attr;
    logic [2:0]  boot_seg_cache_attr;
    logic        cache_sets_write_unlock;
    logic        write_through_merge;
    logic [2:0]  icache_sets;
    logic [2:0]  dcache_sets;
    logic [3:0]  l2_sets;
    logic [31:0] impl;
    logic [31:0] rdata;
    logic        rvalid;
  } ccc_state_s;

  ccc_state_s st;
  ccc_state_s next_st;

  logic [31:0] core_configuration;
  logic [31:0] cache_capability_reg;
  logic [31:0] l2_l3_capability_reg;
  logic [31:0] extension_capability_reg;

  // Only sizes no larger than fitted are taken; growing past the
  // real array would index sets that do not exist.
  function automatic logic [3:0] shrink(input logic [3:0] cur,
                                        input logic [3:0] req_v,
                                        input logic [3:0] lim);
    shrink = (req_v <= lim) ? req_v : cur;
  endfunction

  // ---------------------------------------------------------------
  // Register images
  // ---------------------------------------------------------------
  always_comb begin
    core_configuration = 32'h0000_0000;
    core_configuration[CFG_M_BIT] = 1'b1;
    core_configuration[CFG_K23_LSB +: 3] =
      st.high_kernel_seg_cache_attr;
    core_configuration[CFG_KU_LSB +: 3] = st.user_seg_cache_attr;
    core_configuration[CFG_ISP_BIT] = HAS_ISPRAM;
    core_configuration[CFG_DSP_BIT] = HAS_DSPRAM;
    core_configuration[CFG_UDI_BIT] = HAS_UDI;
    core_configuration[CFG_SB_BIT]  = SIMPLE_BE;
    core_configuration[CFG_WC_BIT]  = st.cache_sets_write_unlock;
    core_configuration[CFG_MM_BIT]  = st.write_through_merge;
    core_configuration[CFG_BM_BIT]  = BURST_SUBBLK;
    core_configuration[CFG_BE_BIT]  = BIG_ENDIAN;
    core_configuration[CFG_MT_LSB +: 3] = HAS_TLB ? MT_TLB : MT_FIXED;
    core_configuration[CFG_AR_LSB +: 3] = 3'h1;
    core_configuration[CFG_K0_LSB +: 3] = st.boot_seg_cache_attr;

    cache_capability_reg = CACHE_FIXED;
    cache_capability_reg[C1_IS_LSB +: 3] = st.icache_sets;
    cache_capability_reg[C1_DS_LSB +: 3] = st.dcache_sets;
    l2_l3_capability_reg = L2L3_FIXED;
    l2_l3_capability_reg[C2_SS_LSB +: 4] = st.l2_sets;
    extension_capability_reg = EXT_FIXED;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rvalid = req.rd;
    if (req.rd) begin
      unique case (req.sel)
        SEL_CORE_CFG: next_st.rdata = core_configuration;
        SEL_CACHE:    next_st.rdata = cache_capability_reg;
        SEL_L2L3:     next_st.rdata = l2_l3_capability_reg;
        SEL_EXT:      next_st.rdata = extension_capability_reg;
        SEL_IMPL:     next_st.rdata = (st.impl & IMPL_WMASK) |
                                      (IMPL_RO & ~IMPL_WMASK);
        default:      next_st.rdata = 32'h0000_0000;
      endcase
    end
    if (req.wr) begin
      unique case (req.sel)
        SEL_CORE_CFG: begin
          // Only the writable fields are taken
          next_st.high_kernel_seg_cache_attr =
            req.wdata[CFG_K23_LSB +: 3];
          next_st.user_seg_cache_attr = req.wdata[CFG_KU_LSB +: 3];
          next_st.boot_seg_cache_attr = req.wdata[CFG_K0_LSB +: 3];
          next_st.cache_sets_write_unlock = req.wdata[CFG_WC_BIT];
          next_st.write_through_merge = req.wdata[CFG_MM_BIT];
        end
        SEL_CACHE: begin
          if (st.cache_sets_write_unlock) begin
            next_st.icache_sets = 3'(shrink({1'b0, st.icache_sets},
              {1'b0, req.wdata[C1_IS_LSB +: 3]}, {1'b0, IS_MAX}));
            next_st.dcache_sets = 3'(shrink({1'b0, st.dcache_sets},
              {1'b0, req.wdata[C1_DS_LSB +: 3]}, {1'b0, DS_MAX}));
          end
        end
        SEL_L2L3: begin
          if (st.cache_sets_write_unlock && HAS_L2) begin
            next_st.l2_sets = shrink(st.l2_sets,
              req.wdata[C2_SS_LSB +: 4], SS_MAX);
          end
        end
        SEL_IMPL: next_st.impl = req.wdata & IMPL_WMASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st.high_kernel_seg_cache_attr <= RST_SEG_ATTR;
      st.user_seg_cache_attr        <= RST_SEG_ATTR;
      st.boot_seg_cache_attr        <= RST_BOOT_ATTR;
      st.cache_sets_write_unlock    <= RST_WC;
      st.write_through_merge        <= RST_MM;
      st.icache_sets                <= IS_MAX;
      st.dcache_sets                <= DS_MAX;
      st.l2_sets                    <= SS_MAX;
      st.impl                       <= RST_IMPL;
      st.rdata                      <= 32'h0000_0000;
      st.rvalid                     <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Uses of the settings
  // ---------------------------------------------------------------
  always_comb begin
    if (fetch_addr[31:29] == 3'h4) begin
      seg_attr = st.boot_seg_cache_attr;
    end else if (fetch_addr[31:29] == 3'h5) begin
      seg_attr = ATTR_UNCACHED;
    end else if (HAS_TLB) begin
      seg_attr = tlb_attr;
    end else if (fetch_addr[31:30] == 2'h3) begin
      seg_attr = st.high_kernel_seg_cache_attr;
    end else begin
      seg_attr = st.user_seg_cache_attr;
    end
  end

  // Simple mode: single byte, aligned halfword or full word only
  always_comb begin
    if (!SIMPLE_BE) begin
      be_legal = (be_req != 4'h0);
    end else begin
      unique case (be_req)
        4'h1, 4'h2, 4'h4, 4'h8, 4'hf: be_legal = 1'b1;
        4'h3: be_legal = (be_addr[1] == 1'b0);
        4'hc: be_legal = (be_addr[1] == 1'b1);
        default: be_legal = 1'b0;
      endcase
    end
  end

  // Writebacks move whole blocks and uncached writes never merge
  assign merge_ok = st.write_through_merge &&
                    (wr_kind == ccc_wr_wthru);

  assign simple_byte_enable_mode  = SIMPLE_BE;
  assign rdata                    = st.rdata;
  assign rvalid                   = st.rvalid;
  assign icache_sets_per_way      = st.icache_sets;
  assign dcache_sets_per_way      = st.dcache_sets;
  assign l2_sets_per_way          = st.l2_sets;
  assign impl_specific_config_reg = st.impl;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  cont_bit_a: assert property (@(posedge clk) disable iff (srst)
    rvalid && $past(req.sel) == SEL_CORE_CFG |-> rdata[CFG_M_BIT])
    else $error("continuation bit not 1");

  boot_reset_a: assert property (@(posedge clk)
    $past(srst) |-> st.boot_seg_cache_attr == 3'h2)
    else $error("boot attribute not 2 after reset");

  seg_write_a: assert property (@(posedge clk) disable iff (srst)
    req.wr && req.sel == SEL_CORE_CFG |=>
      st.boot_seg_cache_attr == $past(req.wdata[2:0]) &&
      st.high_kernel_seg_cache_attr == $past(req.wdata[30:28]))
    else $error("segment attribute write lost");

  high_seg_a: assert property (@(posedge clk) disable iff (srst)
    !HAS_TLB && fetch_addr >= 32'hc000_0000 |->
      seg_attr == st.high_kernel_seg_cache_attr)
    else $error("high kernel attribute not applied");

  user_seg_a: assert property (@(posedge clk) disable iff (srst)
    !HAS_TLB && fetch_addr <= 32'h7fff_ffff |->
      seg_attr == st.user_seg_cache_attr)
    else $error("user attribute not applied");

  tlb_ignore_a: assert property (@(posedge clk) disable iff (srst)
    HAS_TLB && !fetch_addr[31] |-> seg_attr == tlb_attr)
    else $error("user attribute used with translation buffer");

  sets_lock_a: assert property (@(posedge clk) disable iff (srst)
    !st.cache_sets_write_unlock |=> $stable(st.icache_sets) &&
      $stable(st.dcache_sets))
    else $error("sets changed while locked");

  cap_ro_a: assert property (@(posedge clk) disable iff (srst)
    rvalid && $past(req.sel) == SEL_EXT |-> rdata == EXT_FIXED)
    else $error("capability register not fixed");

  merge_kind_a: assert property (@(posedge clk) disable iff (srst)
    wr_kind != ccc_wr_wthru |-> !merge_ok)
    else $error("merge on non write-through store");

  simple_be_a: assert property (@(posedge clk) disable iff (srst)
    SIMPLE_BE && be_req == 4'h6 |-> !be_legal)
    else $error("unaligned byte enables allowed");

  boot_seg_a: assert property (@(posedge clk) disable iff (srst)
    fetch_addr[31:29] == 3'h4 |-> seg_attr == st.boot_seg_cache_attr)
    else $error("boot attribute not applied");

  any_be_a: assert property (@(posedge clk) disable iff (srst)
    !SIMPLE_BE && be_req != 4'h0 |-> be_legal)
    else $error("byte enables refused in free mode");

  merge_on_a: assert property (@(posedge clk) disable iff (srst)
    st.write_through_merge && wr_kind == ccc_wr_wthru |-> merge_ok)
    else $error("write-through merge not granted");

  l2_lock_a: assert property (@(posedge clk) disable iff (srst)
    !st.cache_sets_write_unlock |=> $stable(st.l2_sets))
    else $error("second-level sets changed while locked");

  ro_fields_a: assert property (@(posedge clk) disable iff (srst)
    rvalid && $past(req.sel) == SEL_CORE_CFG |->
      rdata[CFG_SB_BIT] == SIMPLE_BE &&
      rdata[CFG_MT_LSB +: 3] == (HAS_TLB ? MT_TLB : MT_FIXED))
    else $error("read-only configuration field changed");

endmodule

// *** sim/ccc_regs_bench.sv ***
/*
  Self-checking bench for the configuration and capability registers.
  Assumes ccc_pkg and ccc_regs are compiled first; the bench drives every
  input itself at the falling clock edge.
*/
`timescale 1ns/1ps
module ccc_regs_bench;
  import ccc_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int         TIMEOUT = 4000;
  localparam bit [31:0]  C1_FIX  = 32'h8000_0000;
  localparam bit [31:0]  C2_FIX  = 32'h8000_0000;
  localparam bit [31:0]  IMPL_WM = 32'h0000_00ff;
  logic                  clk;
  logic                  srst;
  ccc_req_s              req;
  logic [31:0]           rdata;
  logic                  rvalid;
  logic [31:0]           fetch_addr;
  logic [2:0]            tlb_attr;
  logic [2:0]            seg_attr;
  logic [1:0]            be_addr;
  logic [3:0]            be_req;
  logic                  be_legal;
  logic                  sbe_mode;
  ccc_wr_kind_e          wr_kind;
  logic                  merge_ok;
  logic [2:0]            is_o;
  logic [2:0]            ds_o;
  logic [3:0]            ss_o;
  logic [31:0]           impl_o;
  int                    err_count;
  int                    checks_done;
  int                    cycles;
  int                    seed;
  logic [2:0]            k23;
  logic [2:0]            ku;
  logic [2:0]            k0;
  logic                  wc;
  logic                  mm;
  logic [31:0]           w;
  logic [31:0]           corners [6];
  ccc_req_s              req_tlb;
  logic [2:0]            seg_t;
  logic                  be_legal_t;
  logic                  sbe_t;

  ccc_regs #(.HAS_ISPRAM(1'b1), .HAS_UDI(1'b1), .HAS_L2(1'b1),
    .DCACHE_SETS(3), .L2_SETS(4), .CACHE_FIXED(C1_FIX),
    .L2L3_FIXED(C2_FIX), .IMPL_WMASK(IMPL_WM)) dut (
    .clk(clk), .srst(srst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .fetch_addr(fetch_addr), .tlb_attr(tlb_attr), .seg_attr(seg_attr),
    .be_addr(be_addr), .be_req(be_req), .be_legal(be_legal),
    .simple_byte_enable_mode(sbe_mode), .wr_kind(wr_kind),
    .merge_ok(merge_ok), .icache_sets_per_way(is_o),
    .dcache_sets_per_way(ds_o), .l2_sets_per_way(ss_o),
    .impl_specific_config_reg(impl_o));

  // Software keeps the mapped-segment attributes at zero with a TLB
  always_comb begin
    req_tlb = req;
    req_tlb.wdata[30:25] = 6'h0;
  end

  // Translation buffer fitted, free byte enables
  ccc_regs #(.HAS_TLB(1'b1), .SIMPLE_BE(1'b0)) dut_tlb (
    .clk(clk), .srst(srst), .req(req_tlb), .rdata(), .rvalid(),
    .fetch_addr(fetch_addr), .tlb_attr(tlb_attr), .seg_attr(seg_t),
    .be_addr(be_addr), .be_req(be_req), .be_legal(be_legal_t),
    .simple_byte_enable_mode(sbe_t), .wr_kind(wr_kind), .merge_ok(),
    .icache_sets_per_way(), .dcache_sets_per_way(), .l2_sets_per_way(),
    .impl_specific_config_reg());

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == TIMEOUT) begin
      err_count++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic rd(input logic [2:0] s, output logic [31:0] d);
    req.rd = 1'b1;
    req.sel = s;
    @(negedge clk);
    req.rd = 1'b0;
    chk_flag(rvalid, 1'b1);
    d = rdata;
    @(negedge clk);
  endtask

  task automatic wr(input logic [2:0] s, input logic [31:0] d);
    req.wr = 1'b1;
    req.sel = s;
    req.wdata = d;
    @(negedge clk);
    req.wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, err_count);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Fixed fields follow the parameters given to the instance
  function automatic logic [31:0] exp_cfg();
    return {1'b1, k23, ku, 4'hb, 1'b0, wc, mm, 3'h0, 2'h0, 3'h1,
            MT_FIXED, 4'h0, k0};
  endfunction

  function automatic logic [31:0] exp_c1(input logic [2:0] i,
                                         input logic [2:0] d);
    logic [31:0] v;
    v = C1_FIX;
    v[24:22] = i;
    v[15:13] = d;
    return v;
  endfunction

  function automatic logic [2:0] exp_seg(input logic [31:0] a);
    if (a[31:30] == 2'b11) return k23;
    if (!a[31]) return ku;
    if (!a[29]) return k0;
    return ATTR_UNCACHED;
  endfunction

  function automatic logic [2:0] exp_seg_t(input logic [31:0] a);
    if (!a[31] || a[31:30] == 2'b11) return tlb_attr;
    return exp_seg(a);
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 37945;
    req = '0;
    srst = 1'b1;
    fetch_addr = 32'h0;
    tlb_attr = 3'h0;
    be_addr = 2'h0;
    be_req = 4'h0;
    wr_kind = ccc_wr_wthru;
    {err_count, checks_done, cycles} = '0;
    {k23, ku, wc, mm} = '0;
    k0 = RST_BOOT_ATTR;
    corners = '{32'hc000_0000, 32'hffff_ffff, 32'h0, 32'h7fff_ffff,
                32'h8000_0000, 32'hbfff_ffff};
    repeat (10) @(negedge clk);
    srst = 1'b0;
    rd(SEL_CORE_CFG, w);
    chk_word(w, exp_cfg());
    chk_word(impl_o, RST_IMPL);
    chk_flag(sbe_mode, 1'b1);
    chk_flag(sbe_t, 1'b0);
    end_test("reset");
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 32'h0004_0003 : $random(seed);
      wr(SEL_CORE_CFG, w);
      {k23, ku} = w[30:25];
      k0 = w[2:0];
      wc = w[19];
      mm = w[18];
      rd(SEL_CORE_CFG, w);
      chk_word(w, exp_cfg());
      for (int j = 0; j < 8; j++) begin
        fetch_addr = (j < 6) ? corners[j] : $random(seed);
        tlb_attr = 3'($random(seed));
        #1 chk_word({29'h0, seg_attr}, {29'h0, exp_seg(fetch_addr)});
        chk_word({29'h0, seg_t}, {29'h0, exp_seg_t(fetch_addr)});
        @(negedge clk);
      end
      for (int k = 0; k < 4; k++) begin
        wr_kind = ccc_wr_kind_e'(k);
        #1 chk_flag(merge_ok, mm && k == 0);
        @(negedge clk);
      end
    end
    end_test("core config");
    wr(SEL_CORE_CFG, 32'h0);
    {k23, ku, k0, wc, mm} = '0;
    wr(SEL_CACHE, $random(seed));
    wr(SEL_L2L3, $random(seed));
    wr(SEL_EXT, $random(seed));
    rd(SEL_CACHE, w);
    chk_word(w, exp_c1(3'h2, 3'h3));
    rd(SEL_L2L3, w);
    chk_word(w, C2_FIX | 32'h0000_0400);
    rd(SEL_EXT, w);
    chk_word(w, 32'h0000_0000);
    for (int s = 4; s < 7; s++) begin
      rd(3'(s), w);
      chk_word(w, 32'h0);
    end
    end_test("read only");
    wr(SEL_CORE_CFG, 32'h0008_0000);
    wc = 1'b1;
    wr(SEL_CACHE, exp_c1(3'h7, 3'h7));
    chk_word({26'h0, is_o, ds_o}, {26'h0, 3'h2, 3'h3});
    wr(SEL_CACHE, exp_c1(3'h1, 3'h2));
    wr(SEL_L2L3, C2_FIX | 32'h0000_0300);
    chk_word({22'h0, is_o, ds_o, ss_o}, {22'h0, 3'h1, 3'h2, 4'h3});
    rd(SEL_CACHE, w);
    chk_word(w, exp_c1(3'h1, 3'h2));
    wr(SEL_CORE_CFG, 32'h0);
    wc = 1'b0;
    wr(SEL_CACHE, exp_c1(3'h0, 3'h0));
    chk_word({29'h0, is_o}, {29'h0, 3'h1});
    end_test("sets unlock");
    for (int b = 0; b < 16; b++) begin
      be_req = 4'(b);
      be_addr = b[0] ? 2'd0 : b[1] ? 2'd1 : b[2] ? 2'd2 : b[3] ? 2'd3 : 2'd0;
      #1 chk_flag(be_legal, b inside {1, 2, 4, 8, 3, 12, 15});
      chk_flag(be_legal_t, b != 0);
      @(negedge clk);
    end
    end_test("byte enables");
    w = $random(seed);
    wr(SEL_IMPL, w);
    chk_word(impl_o, w & IMPL_WM);
    end_test("impl");
    conclude();
  end
endmodule
